// *** hdl/smsv_pkg.sv ***
/*
 * package for the management-message checker and link recovery exit sequencer:
 * message kinds, alert codes, verdicts, carrier structs, register map, timing.
 * assumes a 50 MHz clock and an Avalon-MM slave with 32-bit data.
 */
package smsv_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ          = 50;
	localparam int ACK_TMO_MIN_US   = 100;
	localparam int ACK_TMO_MAX_US   = 200;
	localparam int ACK_TMO_US       = 150;
	localparam int ACK_TMO_CYC      = ACK_TMO_US * CLK_MHZ;
	localparam int ACK_TMO_W        = 16;

	// ---------------------------------------------------------------
	// message codes (internal numbering)
	// ---------------------------------------------------------------
	localparam logic [7:0] C_NONE    = 8'h00;
	localparam logic [7:0] C_QNODE   = 8'h01;
	localparam logic [7:0] C_QNODE_R = 8'h02;
	localparam logic [7:0] C_CFGPORT = 8'h03;
	localparam logic [7:0] C_RESP    = 8'h04;
	localparam logic [7:0] C_AALERT  = 8'h05;
	localparam logic [7:0] C_MALERT  = 8'h06;
	localparam logic [7:0] C_QUIESCE = 8'h07;
	localparam logic [7:0] C_AREPLY  = 8'h08;
	localparam logic [7:0] C_QPROT   = 8'h09;
	localparam logic [7:0] C_QPROT_R = 8'h0a;
	localparam logic [7:0] C_QPORT   = 8'h0b;
	localparam logic [7:0] C_QPORT_R = 8'h0c;
	localparam logic [7:0] C_DRDY    = 8'h0d;
	localparam logic [7:0] C_DREPLY  = 8'h0e;
	localparam logic [7:0] C_DREQ    = 8'h0f;
	localparam logic [7:0] C_LAST    = 8'h0f;
	localparam logic [7:0] MIN_LEN   = 8'h04;

	// ---------------------------------------------------------------
	// alert codes (arbitrary internal values)
	// ---------------------------------------------------------------
	localparam logic [7:0] A_UNKNOWN   = 8'h10;
	localparam logic [7:0] A_TOO_SHORT = 8'h11;
	localparam logic [7:0] A_BAD_ROUTE = 8'h12;

	// verdicts on one message
	typedef enum logic [3:0] {
		V_NONE, V_REPLY_NORMAL, V_RESP_INVF, V_AREPLY_INVF, V_DISCARD,
		V_CANCEL_IO, V_CLEAR_ALERT, V_IGNORE, V_LOG_IGNORE, V_ABORT_IO,
		V_ACCEPT
	} smsv_verdict_t;

	// received message summary presented by the frame layer
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] length;
		logic       frame_type_ok;
		logic       supported;
		logic       route_known;
		logic       tag_valid;
		logic       resp_proper;
		logic       data_xfer;
		logic       in_context;
		logic       reserved_nz;
	} smsv_msg_t;

	// answer of the checker
	typedef struct packed {
		smsv_verdict_t verdict;
		logic          alert;
		logic [7:0]    alert_code;
		logic          master_alert;
	} smsv_res_t;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [3:0] R_CTRL   = 4'h0;
	localparam logic [3:0] R_STATUS = 4'h4;
	localparam logic [3:0] R_ALERT  = 4'h8;
	localparam logic [3:0] R_TMO    = 4'hc;
	localparam int B_OPER  = 0;
	localparam int B_LDIST = 1;
	localparam int B_PRIV  = 2;
	localparam int B_CFGM  = 3;
	localparam int B_QNRX  = 4;
	localparam int B_AAVAL = 5;
	localparam int B_LDCAP = 6;
	localparam int B_QCLR  = 0;    // status: write one to release the queue

endpackage

// *** hdl/smsv_core.sv ***
/*
 * management-message checker plus the unsuccessful-recovery exit sequence
 * for one port.
 * assumes the frame layer presents one decoded message summary per strobe
 * and the recovery engine pulses an exit request with its alert code.
 */
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - on failed recovery exit, first clear the port operational flag
// - next turn off long-distance option, set ack timeout 100 to 200 us; code does both only when ld_cap is set
// - then enter privileged mode; transmitter drops application frames
// - then raise alert carrying the exit's alert code
// - only after the alert, restart the port
// - check messages in fixed order, unknown through reserved fields
// - unrecognised code: stop parsing, alert unknown message
// - unsupported code or wrong frame type: alert unknown message
// - message too short for its code: alert too short
// - longer than defined length is accepted
// - responder with unknown reply route index: no response, alert bad route
// - manager ignores invalid tag or improper response, optional logging
// - invalid tag on data transfer: issue abort for the I/O process
// - out of context discarded; manager logs, responder ignores
// - out of context cases: unmatched data reply, wrong-direction I/O, stray reply
// - reserved field violations still parsed and answered on return path
// - query node answered normally; query node reply gets nothing
// - listed commands with reserved violation get invalid-field response
// - async alert violation: invalid-field async reply plus master alert
// - reply-type violations: clear alert, discard, or cancel I/O
// - alerts dropped before query reply seen, queued while delivery disabled
module smsv_core
	import smsv_pkg::*;
#(
	parameter int ACK_CYC = ACK_TMO_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        msg_valid,
	input  wire smsv_msg_t   msg,
	output smsv_res_t        res,
	output logic             res_valid,
	input  wire logic        exit_req,
	input  wire logic [7:0]  exit_code,
	output logic             port_restart,
	output logic             tx_drop_app,
	output logic             alert_valid,
	output logic      [7:0]  alert_code,
	output logic             alert_queued,
	output logic [ACK_TMO_W-1:0] ack_timeout
);

	// ---------------------------------------------------------------
	// parameter limits
	// ---------------------------------------------------------------
	// the timeout must land inside the legal window and fit the output
	localparam int ACK_LO_CYC  = ACK_TMO_MIN_US * CLK_MHZ;
	localparam int ACK_HI_CYC  = ACK_TMO_MAX_US * CLK_MHZ;
	localparam int ACK_TOP_CYC = (1 << ACK_TMO_W) - 1;

	if (ACK_CYC < ACK_LO_CYC || ACK_CYC > ACK_HI_CYC) begin
		$error("ACK_CYC outside the legal ack timeout window");
	end
	if (ACK_CYC > ACK_TOP_CYC) begin
		$error("ACK_CYC does not fit the ack_timeout output");
	end

	// one state per exit action, in the order the actions must happen
	typedef enum logic [2:0] {
		S_IDLE, S_OPER, S_LDIST, S_PRIV, S_ALERT, S_RESTART
	} smsv_exit_t;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	// exit walk position and the alert code it carries
	smsv_exit_t            st, next_st;
	logic [7:0]            code_hold, next_code_hold;
	// port flags; oper leaves reset set so a fresh port can carry traffic
	logic                  oper, next_oper;
	logic                  ldist, next_ldist;
	logic                  priv, next_priv;
	// node role and alert gating; qn_seen set by a parsed query reply, the rest written by software
	logic                  cfgm, next_cfgm;
	logic                  qn_seen, next_qn_seen;
	logic                  aa_valid, next_aa_valid;
	logic                  ld_cap, next_ld_cap;
	// next values of the registered outputs
	logic [ACK_TMO_W-1:0]  next_ack_timeout;
	logic                  next_restart;
	logic                  next_alert_valid;
	logic [7:0]            next_alert_code;
	logic                  next_alert_queued;
	logic [7:0]            last_alert, next_last_alert;
	smsv_res_t             next_res;
	logic                  next_res_valid;
	// register slave
	logic [31:0]           next_rdata;
	logic                  next_wait;
	logic                  acc;

	// message judgement, pure decode
	smsv_res_t chk;
	logic      raise;
	logic [7:0] raise_code;

	// ---------------------------------------------------------------
	// message checker
	// ---------------------------------------------------------------
	// order matters: earlier faults hide later ones
	always_comb begin
		chk = '{verdict: V_ACCEPT, alert: 1'b0, alert_code: 8'h00, master_alert: 1'b0};
		// the code fixes the layout, so nothing else is read before it passes
		if (msg.code == C_NONE || msg.code > C_LAST) begin
			chk.verdict    = V_NONE;
			chk.alert      = 1'b1;
			chk.alert_code = A_UNKNOWN;
		end else if (!msg.supported || !msg.frame_type_ok) begin
			chk.verdict    = V_NONE;
			chk.alert      = 1'b1;
			chk.alert_code = A_UNKNOWN;
		end else if (msg.length < MIN_LEN) begin
			chk.verdict    = V_NONE;
			chk.alert      = 1'b1;
			chk.alert_code = A_TOO_SHORT;
		end else if (!cfgm && !msg.route_known) begin
			// no route exists to answer on, so only the alert goes out
			chk.verdict    = V_NONE;
			chk.alert      = 1'b1;
			chk.alert_code = A_BAD_ROUTE;
		end else if (!msg.tag_valid && msg.data_xfer) begin
			// abort in either role; the upper layer owns the I/O process
			chk.verdict    = V_ABORT_IO;
		end else if (cfgm && (!msg.tag_valid || !msg.resp_proper)) begin
			chk.verdict    = V_LOG_IGNORE;
		end else if (!msg.in_context) begin
			chk.verdict    = cfgm ? V_LOG_IGNORE : V_IGNORE;
		end else if (msg.reserved_nz) begin
			// the kind of message alone picks the answer to reserved content
			case (msg.code)
				C_QNODE:   chk.verdict = V_REPLY_NORMAL;
				C_QNODE_R: chk.verdict = V_NONE;
				C_AALERT: begin
					chk.verdict      = V_AREPLY_INVF;
					chk.master_alert = 1'b1;
				end
				C_AREPLY:  chk.verdict = V_CLEAR_ALERT;
				C_RESP, C_QPROT_R, C_QPORT_R: chk.verdict = V_DISCARD;
				C_DRDY, C_DREQ: chk.verdict = V_CANCEL_IO;
				default:   chk.verdict = V_RESP_INVF;
			endcase
		end else if (msg.code == C_QNODE) begin
			// a clean query still earns its normal reply
			chk.verdict = V_REPLY_NORMAL;
		end
	end

	// ---------------------------------------------------------------
	// exit sequencer
	// ---------------------------------------------------------------
	// one action per cycle keeps the documented order observable
	always_comb begin
		next_st          = st;
		next_code_hold   = code_hold;
		next_oper        = oper;
		next_ldist       = ldist;
		next_priv        = priv;
		next_ack_timeout = ack_timeout;
		next_restart     = 1'b0;
		raise            = 1'b0;
		raise_code       = 8'h00;
		case (st)
			S_IDLE: begin
				if (exit_req) begin
					next_code_hold = exit_code;
					next_st        = S_OPER;
				end
			end
			S_OPER: begin
				// clearing oper first stops new traffic being routed here
				next_oper = 1'b0;
				next_st   = S_LDIST;
			end
			S_LDIST: begin
				// a port without the option keeps its timeout untouched
				if (ld_cap) begin
					next_ldist       = 1'b0;
					next_ack_timeout = ACK_CYC[ACK_TMO_W-1:0];
				end
				next_st = S_PRIV;
			end
			S_PRIV: begin
				// privileged mode also gates application frames at the transmitter
				next_priv = 1'b1;
				next_st   = S_ALERT;
			end
			S_ALERT: begin
				// the alert leaves a cycle before the restart; the gate still drops it if no query reply has been seen
				raise      = 1'b1;
				raise_code = code_hold;
				next_st    = S_RESTART;
			end
			S_RESTART: begin
				next_restart = 1'b1;
				next_st      = S_IDLE;
			end
			default: next_st = S_IDLE;
		endcase
		// software writes override the sequencer only when it is idle
		if (acc && avs_write && avs_address == R_CTRL && st == S_IDLE) begin
			next_oper  = avs_writedata[B_OPER];
			next_ldist = avs_writedata[B_LDIST] & ld_cap;
			next_priv  = avs_writedata[B_PRIV];
		end
	end

	// ---------------------------------------------------------------
	// alert gate, results and register slave
	// ---------------------------------------------------------------
	always_comb begin
		logic        want;
		logic [7:0]  wcode;
		// at most one alert per cycle; the gate decides deliver, queue or drop
		want              = raise | (msg_valid & chk.alert);
		wcode             = raise ? raise_code : chk.alert_code;
		next_alert_valid  = 1'b0;
		next_alert_code   = alert_code;
		next_alert_queued = alert_queued;
		next_last_alert   = last_alert;
		next_cfgm         = cfgm;
		next_qn_seen      = qn_seen;
		next_aa_valid     = aa_valid;
		next_ld_cap       = ld_cap;
		// a message-side alert colliding with an exit alert is dropped;
		// the exit alert is the more severe of the two
		if (want && qn_seen) begin
			next_last_alert = wcode;
			next_alert_code = wcode;
			// a waiting alert blocks direct delivery so alerts keep their order
			if (!aa_valid || alert_queued)
				next_alert_queued = 1'b1;
			else
				next_alert_valid = 1'b1;
		end
		// alerts stay dropped until a query reply has been parsed
		if (msg_valid && msg.code == C_QNODE_R && chk.verdict != V_NONE)
			next_qn_seen = 1'b1;
		next_res       = msg_valid ? chk : res;
		next_res_valid = msg_valid;
		next_rdata     = 32'h0000_0000;
		// one wait state: the slave answers in the cycle after it sees a request
		next_wait      = 1'b1;
		if ((avs_read || avs_write) && avs_waitrequest)
			next_wait = 1'b0;
		if (acc && avs_write) begin
			if (avs_address == R_CTRL) begin
				next_cfgm     = avs_writedata[B_CFGM];
				next_aa_valid = avs_writedata[B_AAVAL];
				next_ld_cap   = avs_writedata[B_LDCAP];
			end else if (avs_address == R_STATUS) begin
				// writing one releases the queue; a new alert this cycle wins
				if (avs_writedata[B_QCLR] && !(want && qn_seen))
					next_alert_queued = 1'b0;
			end
		end
		// read data is prepared while waitrequest is still high
		if ((avs_read || avs_write) && avs_waitrequest) begin
			if (avs_address == R_CTRL)
				next_rdata = {25'h0, ld_cap, aa_valid, qn_seen, cfgm, priv, ldist, oper};
			else if (avs_address == R_STATUS)
				next_rdata = {28'h0, (st != S_IDLE), priv, oper, alert_queued};
			else if (avs_address == R_ALERT)
				next_rdata = {24'h0, last_alert};
			else if (avs_address == R_TMO)
				next_rdata = {{(32-ACK_TMO_W){1'b0}}, ack_timeout};
			else
				next_rdata = 32'h0000_0000;
		end
	end

	// an access completes on the edge where waitrequest is seen low
	assign acc = (avs_read || avs_write) && !avs_waitrequest;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// reset leaves the port operational and the bus stalled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st              <= S_IDLE;
			code_hold       <= 8'h00;
			oper            <= 1'b1;
			ldist           <= 1'b0;
			priv            <= 1'b0;
			cfgm            <= 1'b0;
			qn_seen         <= 1'b0;
			aa_valid        <= 1'b0;
			ld_cap          <= 1'b0;
			ack_timeout     <= '0;
			port_restart    <= 1'b0;
			tx_drop_app     <= 1'b0;
			alert_valid     <= 1'b0;
			alert_code      <= 8'h00;
			alert_queued    <= 1'b0;
			last_alert      <= 8'h00;
			res             <= '0;
			res_valid       <= 1'b0;
			avs_readdata    <= 32'h0000_0000;
			avs_waitrequest <= 1'b1;
		end else begin
			st              <= next_st;
			code_hold       <= next_code_hold;
			oper            <= next_oper;
			ldist           <= next_ldist;
			priv            <= next_priv;
			cfgm            <= next_cfgm;
			qn_seen         <= next_qn_seen;
			aa_valid        <= next_aa_valid;
			ld_cap          <= next_ld_cap;
			ack_timeout     <= next_ack_timeout;
			port_restart    <= next_restart;
			tx_drop_app     <= next_priv;
			alert_valid     <= next_alert_valid;
			alert_code      <= next_alert_code;
			alert_queued    <= next_alert_queued;
			last_alert      <= next_last_alert;
			res             <= next_res;
			res_valid       <= next_res_valid;
			avs_readdata    <= next_rdata;
			avs_waitrequest <= next_wait;
		end
	end

endmodule

`default_nettype wire

// *** bench/smsv_props.sv ***
/*
 * port checker for smsv_core: message verdict timing and the
 * failed-recovery exit walk.
 * assumes one clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module smsv_props
	import smsv_pkg::*;
#(
	parameter int ACK_CYC = ACK_TMO_CYC
) (
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic                 msg_valid,
	input wire smsv_msg_t            msg,
	input wire smsv_res_t            res,
	input wire logic                 res_valid,
	input wire logic                 exit_req,
	input wire logic [7:0]           exit_code,
	input wire logic                 port_restart,
	input wire logic                 tx_drop_app,
	input wire logic                 alert_valid,
	input wire logic [7:0]           alert_code,
	input wire logic                 alert_queued,
	input wire logic [ACK_TMO_W-1:0] ack_timeout
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// message screens in check order
	wire logic code_ok = msg.code != 8'h00 && msg.code <= C_LAST;
	wire logic hdr_ok  = code_ok && msg.supported && msg.frame_type_ok;
	wire logic len_ok  = hdr_ok && msg.length >= MIN_LEN;
	wire logic all_ok  = len_ok && msg.route_known && msg.tag_valid && msg.resp_proper
		&& msg.in_context && !msg.reserved_nz;
	logic [2:0] seq;
	logic [2:0] next_seq;
	localparam int ACK_LO = ACK_TMO_MIN_US * CLK_MHZ;
	localparam int ACK_HI = ACK_TMO_MAX_US * CLK_MHZ;

	// exit walk position; a request in mid-walk is not taken, so do not restart
	always_comb begin
		next_seq = 3'h0;
		if (seq == 3'h0 && exit_req)
			next_seq = 3'h1;
		else if (seq != 3'h0 && seq != 3'h5)
			next_seq = seq + 3'h1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			seq <= 3'h0;
		else
			seq <= next_seq;
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_RES_LAT: assert property (msg_valid |=> res_valid)
		else $error("no result one cycle after message");
	AST_RES_HOLD: assert property (!res_valid |-> $stable(res))
		else $error("result moved without a message");
	AST_UNKNOWN: assert property (
		msg_valid && !code_ok |=> res.alert && res.alert_code == A_UNKNOWN)
		else $error("unknown code not alerted");
	AST_UNSUP: assert property (
		msg_valid && code_ok && !hdr_ok |=> res.alert && res.alert_code == A_UNKNOWN)
		else $error("unsupported code not alerted");
	AST_SHORT: assert property (
		msg_valid && hdr_ok && !len_ok |=> res.alert && res.alert_code == A_TOO_SHORT)
		else $error("short message not alerted");
	AST_LONG: assert property (
		msg_valid && all_ok && msg.code != C_QNODE |=> res.verdict == V_ACCEPT && !res.alert)
		else $error("clean message not accepted");
	AST_EXIT_SEQ: assert property (
		exit_req && seq == 3'h0 |-> ##5 tx_drop_app && !port_restart ##1 port_restart)
		else $error("exit walk out of step");
	AST_EXIT_CODE: assert property (
		seq == 3'h5 && alert_valid |-> alert_code == $past(exit_code, 5))
		else $error("exit alert code wrong");
	AST_TMO: assert property (
		ack_timeout != '0 |-> ack_timeout >= ACK_LO && ack_timeout <= ACK_HI)
		else $error("ack timeout outside the legal window");
	cover property (msg_valid && msg.reserved_nz);
	cover property (seq == 3'h5 ##1 port_restart);
	cover property ($rose(alert_queued));
endmodule
`default_nettype wire

// *** bench/smsv_peer.sv ***
/*
 * far-side node model: hands one decoded management message per strobe.
 * assumes its tasks are entered just after a rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module smsv_peer
	import smsv_pkg::*;
(
	input  wire logic clk,
	output logic      msg_valid,
	output smsv_msg_t msg
);
	initial begin
		msg_valid = 1'b0;
		msg       = 24'h000000;
	end
	// released fields show the inverse so a stale copy is never read
	task automatic push(input smsv_msg_t m);
		msg_valid <= 1'b1;
		msg       <= m;
		@(posedge clk);
		msg_valid <= 1'b0;
		msg       <= ~m;
		@(posedge clk);
	endtask
	// manager answer to a bad reply route: quiesce, then query node
	task automatic rebuild();
		push({C_QUIESCE, 8'h08, 8'hfa});
		push({C_QNODE, 8'h08, 8'hfa});
	endtask
endmodule
`default_nettype wire

// *** bench/sms_validation_erp_exit_test.sv ***
/*
 * self-checking bench for smsv_core: register tasks, message screens,
 * recovery exit walk.
 * assumes smsv_peer as message source and smsv_props bound below.
 */
`timescale 1ns/100ps
`default_nettype none
module sms_validation_erp_exit_test
	import smsv_pkg::*;
;
	localparam int ACK = 5000;
	logic                 clk, rst_n, avs_read, avs_write, avs_waitrequest, al;
	logic                 msg_valid, res_valid, exit_req, port_restart;
	logic                 tx_drop_app, alert_valid, alert_queued;
	logic [3:0]           avs_address;
	logic [31:0]          avs_writedata, avs_readdata, rd;
	logic [7:0]           exit_code, alert_code;
	logic [ACK_TMO_W-1:0] ack_timeout;
	smsv_msg_t            msg;
	smsv_res_t            res;
	int                   error_cnt = 0, n_compared = 0, i;
	smsv_verdict_t        rsv_v [15] = '{V_REPLY_NORMAL, V_NONE, V_RESP_INVF, V_DISCARD,
		V_AREPLY_INVF, V_RESP_INVF, V_RESP_INVF, V_CLEAR_ALERT, V_RESP_INVF, V_DISCARD,
		V_RESP_INVF, V_DISCARD, V_CANCEL_IO, V_RESP_INVF, V_CANCEL_IO};
	logic [7:0]           ctx_c [4] = '{C_DREPLY, C_DREQ, C_DRDY, C_AREPLY};

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	smsv_core #(.ACK_CYC(ACK)) dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.msg_valid(msg_valid), .msg(msg), .res(res), .res_valid(res_valid),
		.exit_req(exit_req), .exit_code(exit_code), .port_restart(port_restart),
		.tx_drop_app(tx_drop_app), .alert_valid(alert_valid), .alert_code(alert_code),
		.alert_queued(alert_queued), .ack_timeout(ack_timeout));
	smsv_peer peer (.clk(clk), .msg_valid(msg_valid), .msg(msg));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one bus access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int   n;
		logic ok;
		n = 0;
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		ok = avs_waitrequest === 1'b0;
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		// one idle edge, so a following call never re-raises read in this step
		@(posedge clk);
		if (!ok) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// the verdict lands one cycle after the strobe; an alert comes with it
	task automatic send(input smsv_msg_t m, input smsv_verdict_t v, input logic [7:0] a);
		peer.push(m);
		chk(res_valid, 32'h1);
		chk(res.verdict, v);
		chk(res.alert, a != 8'h00);
		if (a != 8'h00) begin
			chk(res.alert_code, a);
			chk(alert_valid, 32'h1);
		end
	endtask
	// al marks an alert with the exit code seen before the restart
	task automatic exit_walk(input logic [7:0] c);
		int n;
		exit_req  <= 1'b1;
		exit_code <= c;
		@(posedge clk);
		exit_req <= 1'b0;
		al = 1'b0;
		n = 0;
		while (port_restart !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
			if (alert_valid === 1'b1)
				al = alert_code === c;
		end
		chk(port_restart, 32'h1);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		exit_req = 1'b0;
		exit_code = 8'h00;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(R_CTRL, 32'h1);
		rdc(R_STATUS, 32'h2);
		rdc(R_TMO, 32'h0);
		rdc(4'h2, 32'h0);
		bus(1'b1, R_CTRL, 32'h63);
		// no query reply seen yet, so this alert is dropped
		peer.push({8'h00, 8'h05, 8'hfa});
		chk(alert_valid, 32'h0);
		chk(alert_queued, 32'h0);
		send({C_QNODE_R, 8'h04, 8'hfa}, V_ACCEPT, 8'h00);
		send({8'h00, 8'h03, 8'hda}, V_NONE, A_UNKNOWN);
		send({8'h10, 8'h05, 8'hfa}, V_NONE, A_UNKNOWN);
		send({C_CFGPORT, 8'h05, 8'hba}, V_NONE, A_UNKNOWN);
		send({C_CFGPORT, 8'h05, 8'h7a}, V_NONE, A_UNKNOWN);
		send({C_CFGPORT, 8'h03, 8'hda}, V_NONE, A_TOO_SHORT);
		send({C_CFGPORT, 8'h09, 8'hfa}, V_ACCEPT, 8'h00);
		send({C_QPORT, 8'h05, 8'hd8}, V_NONE, A_BAD_ROUTE);
		peer.rebuild();
		chk(res.verdict, V_REPLY_NORMAL);
		send({C_DREPLY, 8'h05, 8'hec}, V_ABORT_IO, 8'h00);
		for (i = 0; i < 4; i++)
			send({ctx_c[i], 8'h05, 8'hf8}, V_IGNORE, 8'h00);
		for (i = 0; i < 15; i++) begin
			send({8'(i + 1), 8'h06, 8'hfb}, rsv_v[i], 8'h00);
			chk(res.master_alert, {31'h0, i == 4});
		end
		// configuration manager role
		bus(1'b1, R_CTRL, 32'h6b);
		send({C_RESP, 8'h05, 8'hea}, V_LOG_IGNORE, 8'h00);
		send({C_RESP, 8'h05, 8'hf2}, V_LOG_IGNORE, 8'h00);
		send({C_QPROT_R, 8'h05, 8'hf8}, V_LOG_IGNORE, 8'h00);
		exit_walk(8'h2a);
		chk(al, 32'h1);
		chk(tx_drop_app, 32'h1);
		rdc(R_STATUS, 32'h4);
		rdc(R_CTRL, 32'h7c);
		rdc(R_TMO, 32'(ACK));
		chk(ack_timeout, 32'(ACK));
		rdc(R_ALERT, 32'h2a);
		// delivery off: the exit alert must wait in the queue
		bus(1'b1, R_CTRL, 32'h4c);
		exit_walk(8'h2b);
		chk(al, 32'h0);
		chk(alert_queued, 32'h1);
		rdc(R_STATUS, 32'h5);
		bus(1'b1, R_STATUS, 32'h1);
		rdc(R_STATUS, 32'h4);
		give_verdict();
	end
endmodule

bind smsv_core smsv_props #(.ACK_CYC(ACK_CYC)) props (.clk(clk), .rst_n(rst_n),
	.msg_valid(msg_valid), .msg(msg), .res(res), .res_valid(res_valid),
	.exit_req(exit_req), .exit_code(exit_code), .port_restart(port_restart),
	.tx_drop_app(tx_drop_app), .alert_valid(alert_valid), .alert_code(alert_code),
	.alert_queued(alert_queued), .ack_timeout(ack_timeout));
`default_nettype wire
